// ==== dac_output_consts.vh ====
// Constants for the DAC output processing controls.
// Assumes inclusion by bare name from the same folder.
`ifndef DAC_OUTPUT_CONSTS_VH
`define DAC_OUTPUT_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_VOLUME_MUTE_ZERO 8'h04
`define OFS_FORMAT_PHASE 8'h05
`define OFS_FILTER_FLAG 8'h06
`define OFS_ROUTING_DITHER 8'h08

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_VOLUME_MUTE_ZERO 8'h00
`define RST_FORMAT_PHASE 8'h00
`define RST_FILTER_FLAG 8'h00
`define RST_ROUTING_DITHER 8'h02

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_ANTI_CLIP 1
`define BIT_SOFT_MUTE 3
`define BIT_ZERO_AUTO_MUTE 4
`define LSB_ZERO_FLAG_SRC 5
`define BIT_PHASE_INVERT 6
`define LSB_DEEMPHASIS_SELECT 5
`define BIT_ZERO_FLAG_FORCE 7
`define BIT_BITSTREAM_GAIN 6
`define LSB_ROUTING 2
`define LSB_DITHER 0

// ----------------------------------------
// Field encodings
// ----------------------------------------
`define ZSRC_AND 2'h0
`define ZSRC_LEFT 2'h1
`define ZSRC_RIGHT 2'h2
`define ROUTE_STEREO 2'h0
`define ROUTE_MONO_LEFT 2'h1
`define ROUTE_SWAPPED 2'h2
`define ROUTE_MONO_RIGHT 2'h3
`define DITHER_OFF 2'h0
`define DITHER_RECT 2'h1
`define DITHER_TRI 2'h2
`define DITHER_HP_TRI 2'h3
`define DEEMPHASIS_SELECT_32K 2'h1
`define DEEMPHASIS_SELECT_44K1 2'h2
`define DEEMPHASIS_SELECT_48K 2'h3

// ----------------------------------------
// Timing counts and arithmetic constants
// ----------------------------------------
`define SOFT_MUTE_SAMPLES 12'hFF8
`define SOFT_MUTE_SHIFT 9
`define ZERO_RUN_LIMIT 11'h400
`define GAIN_UNITY 16'h8000
`define ANTI_CLIP_COEF 18'h065AD
// De-emphasis first-order shelf, Q14: b0, b1, a1
`define DE32_B0 18'h021F9
`define DE32_B1 18'h3FBC5
`define DE32_A1 18'h02242
`define DE44_B0 18'h01DEF
`define DE44_B1 18'h3F966
`define DE44_A1 18'h028AA
`define DE48_B0 18'h01D0D
`define DE48_B1 18'h3F8C1
`define DE48_A1 18'h02A32

`endif

// ==== channel_path.v ====
// One audio channel: dither and truncation, anti-clip, soft mute gain,
// de-emphasis and zero-run detection.
// Assumes one sample_valid_i pulse per sample period.
`timescale 1ns/100ps
`include "dac_output_consts.vh"

module channel_path #(
    parameter IN_W = 32,
    parameter OUT_W = 24
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Sample in
    input wire sample_valid_i,
    input wire [IN_W-1:0] sample_i,
    input wire pcm_mode_i,
    // Controls
    input wire signed [8:0] dither_i,
    input wire anti_clip_i,
    input wire [15:0] gain_i,
    input wire [1:0] deemphasis_select_i,
    // Results
    output reg signed [OUT_W-1:0] data_o,
    output reg zero_det_o
);
    localparam SHIFT = IN_W - OUT_W;
    localparam signed [47:0] MAXV = (48'sd1 <<< (OUT_W - 1)) - 48'sd1;
    localparam signed [47:0] MINV = -(48'sd1 <<< (OUT_W - 1));

    reg [10:0] zero_cnt_reg;
    reg signed [47:0] x1_reg;
    reg signed [47:0] y1_reg;
    reg signed [47:0] dith;
    reg signed [47:0] trunc;
    reg signed [47:0] clip;
    reg signed [47:0] gained;
    reg signed [47:0] filt;
    reg signed [17:0] b0;
    reg signed [17:0] b1;
    reg signed [17:0] a1;

    // Saturate a wide value into the output range
    function signed [47:0] sat;
        input signed [47:0] v;
        begin
            if (v > MAXV) begin
                sat = MAXV;
            end else if (v < MINV) begin
                sat = MINV;
            end else begin
                sat = v;
            end
        end
    endfunction

    // ----------------------------------------
    // Datapath
    // ----------------------------------------
    always @* begin
        // Dither added ahead of the word-length cut
        dith = $signed(sample_i) + dither_i;
        trunc = sat(dith >>> SHIFT);
        clip = anti_clip_i ? ((trunc * $signed(`ANTI_CLIP_COEF)) >>> 15) : trunc;
        gained = (clip * $signed({1'b0, gain_i})) >>> 15;
        case (deemphasis_select_i)
            `DEEMPHASIS_SELECT_32K: begin
                b0 = `DE32_B0;
                b1 = `DE32_B1;
                a1 = `DE32_A1;
            end
            `DEEMPHASIS_SELECT_44K1: begin
                b0 = `DE44_B0;
                b1 = `DE44_B1;
                a1 = `DE44_A1;
            end
            `DEEMPHASIS_SELECT_48K: begin
                b0 = `DE48_B0;
                b1 = `DE48_B1;
                a1 = `DE48_A1;
            end
            default: begin
                b0 = 18'sd0;
                b1 = 18'sd0;
                a1 = 18'sd0;
            end
        endcase
        if (deemphasis_select_i == 2'h0) begin
            filt = gained;
        end else begin
            filt = sat((gained * b0 + x1_reg * b1 + y1_reg * a1) >>> 14);
        end
    end

    // ----------------------------------------
    // Sample registers and zero-run counter
    // ----------------------------------------
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_o <= {OUT_W{1'b0}};
            zero_det_o <= 1'b0;
            zero_cnt_reg <= 11'h000;
            x1_reg <= 48'sd0;
            y1_reg <= 48'sd0;
        end else if (sample_valid_i) begin
            data_o <= filt[OUT_W-1:0];
            x1_reg <= (deemphasis_select_i == 2'h0) ? 48'sd0 : gained;
            y1_reg <= (deemphasis_select_i == 2'h0) ? 48'sd0 : filt;
            if (!pcm_mode_i || sample_i != {IN_W{1'b0}}) begin
                zero_cnt_reg <= 11'h000;
                zero_det_o <= 1'b0;
            end else begin
                if (zero_cnt_reg <= `ZERO_RUN_LIMIT) begin
                    zero_cnt_reg <= zero_cnt_reg + 11'h001;
                end
                zero_det_o <= (zero_cnt_reg >= `ZERO_RUN_LIMIT);
            end
        end
    end
endmodule // channel_path

// ==== dac_output_processing.v ====
// DAC output processing controls: control registers, dither source,
// soft mute gain, zero flag, analogue mute and output routing.
// Assumes register writes arrive decoded from the serial control port,
// and that PCM samples arrive with one valid pulse per sample period.
`timescale 1ns/100ps
`include "dac_output_consts.vh"

module dac_output_processing #(
    parameter IN_W = 32,
    parameter OUT_W = 24
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Control register port
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // Audio samples in
    input wire sample_valid_i,
    input wire [IN_W-1:0] left_in_i,
    input wire [IN_W-1:0] right_in_i,
    input wire pcm_mode_i,
    // Output words to the modulators
    output reg out_valid_o,
    output reg [OUT_W-1:0] left_out_pos_o,
    output reg [OUT_W-1:0] left_out_neg_o,
    output reg [OUT_W-1:0] right_out_pos_o,
    output reg [OUT_W-1:0] right_out_neg_o,
    // Pins and path controls
    output reg zero_flag_out_o,
    output reg mute_pin_n_o,
    output reg bitstream_path_gain_select_o,
    output reg soft_mute_done_o
);
    localparam [OUT_W-1:0] MAX_WORD = {1'b0, {(OUT_W-1){1'b1}}};
    localparam [OUT_W-1:0] MIN_WORD = {1'b1, {(OUT_W-1){1'b0}}};

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg [7:0] volume_mute_zero_control_reg;
    reg [7:0] format_phase_control_reg;
    reg [7:0] filter_flag_control_reg;
    reg [7:0] output_routing_dither_control_reg;
    reg [15:0] lfsr_reg;
    reg [15:0] lfsr_next;
    reg signed [8:0] prev_rand_reg;
    reg signed [8:0] dither_next;
    reg [15:0] gain_reg;
    reg [15:0] gain_next;
    reg [11:0] mute_cnt_reg;
    reg [11:0] mute_cnt_next;
    reg stage_valid_reg;
    reg zero_flag_src;
    reg [OUT_W-1:0] lp_next;
    reg [OUT_W-1:0] ln_next;
    reg [OUT_W-1:0] rp_next;
    reg [OUT_W-1:0] rn_next;
    reg [OUT_W-1:0] left_sel;
    reg [OUT_W-1:0] right_sel;
    reg [7:0] rdata_next;
    wire [OUT_W-1:0] left_word;
    wire [OUT_W-1:0] right_word;
    wire left_zero;
    wire right_zero;

    // Field views of the control registers
    wire anti_clip_enable = volume_mute_zero_control_reg[`BIT_ANTI_CLIP];
    wire soft_mute_enable = volume_mute_zero_control_reg[`BIT_SOFT_MUTE];
    wire zero_auto_mute_enable = volume_mute_zero_control_reg[`BIT_ZERO_AUTO_MUTE];
    wire [1:0] zero_flag_source = volume_mute_zero_control_reg[`LSB_ZERO_FLAG_SRC+1:`LSB_ZERO_FLAG_SRC];
    wire phase_invert = format_phase_control_reg[`BIT_PHASE_INVERT];
    wire [1:0] deemphasis_select = filter_flag_control_reg[`LSB_DEEMPHASIS_SELECT+1:`LSB_DEEMPHASIS_SELECT];
    wire zero_flag_force_high = filter_flag_control_reg[`BIT_ZERO_FLAG_FORCE];
    wire [1:0] output_routing_select = output_routing_dither_control_reg[`LSB_ROUTING+1:`LSB_ROUTING];
    wire [1:0] dither_select = output_routing_dither_control_reg[`LSB_DITHER+1:`LSB_DITHER];

    // Saturating negation of an output word
    function [OUT_W-1:0] invert;
        input [OUT_W-1:0] w;
        begin
            if (w == MIN_WORD) begin
                invert = MAX_WORD;
            end else begin
                invert = ~w + {{(OUT_W-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            volume_mute_zero_control_reg <= `RST_VOLUME_MUTE_ZERO;
            format_phase_control_reg <= `RST_FORMAT_PHASE;
            filter_flag_control_reg <= `RST_FILTER_FLAG;
            output_routing_dither_control_reg <= `RST_ROUTING_DITHER;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `OFS_VOLUME_MUTE_ZERO: volume_mute_zero_control_reg <= reg_wdata_i;
                `OFS_FORMAT_PHASE: format_phase_control_reg <= reg_wdata_i;
                `OFS_FILTER_FLAG: filter_flag_control_reg <= reg_wdata_i;
                `OFS_ROUTING_DITHER: output_routing_dither_control_reg <= reg_wdata_i;
                default: ;
            endcase
        end
    end

    // Read back, unmapped offsets read zero
    always @* begin
        case (reg_addr_i)
            `OFS_VOLUME_MUTE_ZERO: rdata_next = volume_mute_zero_control_reg;
            `OFS_FORMAT_PHASE: rdata_next = format_phase_control_reg;
            `OFS_FILTER_FLAG: rdata_next = filter_flag_control_reg;
            `OFS_ROUTING_DITHER: rdata_next = output_routing_dither_control_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end
    end

    // ----------------------------------------
    // Dither source
    // ----------------------------------------
    // Pseudo-random bytes; shared by both channels
    always @* begin
        lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[14] ^ lfsr_reg[12] ^ lfsr_reg[3]};
        case (dither_select)
            `DITHER_RECT: dither_next = {lfsr_reg[7], lfsr_reg[7:0]};
            `DITHER_TRI: dither_next = $signed({lfsr_reg[7], lfsr_reg[7:0]})
                                     + $signed({lfsr_reg[15], lfsr_reg[15:8]});
            `DITHER_HP_TRI: dither_next = $signed({lfsr_reg[7], lfsr_reg[7:0]}) - prev_rand_reg;
            default: dither_next = 9'sd0;
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lfsr_reg <= 16'hACE1;
            prev_rand_reg <= 9'sd0;
        end else if (sample_valid_i) begin
            lfsr_reg <= lfsr_next;
            prev_rand_reg <= $signed({lfsr_reg[7], lfsr_reg[7:0]});
        end
    end

    // ----------------------------------------
    // Soft mute gain
    // ----------------------------------------
    // Exponential decay, forced to zero at the end of the mute time
    always @* begin
        gain_next = gain_reg;
        mute_cnt_next = mute_cnt_reg;
        if (soft_mute_enable) begin
            if (mute_cnt_reg >= `SOFT_MUTE_SAMPLES - 12'h001) begin
                gain_next = 16'h0000;
                mute_cnt_next = `SOFT_MUTE_SAMPLES;
            end else begin
                mute_cnt_next = mute_cnt_reg + 12'h001;
                if (gain_reg != 16'h0000) begin
                    gain_next = gain_reg - (gain_reg >> `SOFT_MUTE_SHIFT) - 16'h0001;
                end
            end
        end else begin
            gain_next = `GAIN_UNITY;
            mute_cnt_next = 12'h000;
        end
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            gain_reg <= `GAIN_UNITY;
            mute_cnt_reg <= 12'h000;
            soft_mute_done_o <= 1'b0;
        end else if (sample_valid_i) begin
            gain_reg <= gain_next;
            mute_cnt_reg <= mute_cnt_next;
            soft_mute_done_o <= soft_mute_enable && (gain_next == 16'h0000);
        end
    end

    // ----------------------------------------
    // Channel datapaths
    // ----------------------------------------
    channel_path #(
        .IN_W(IN_W),
        .OUT_W(OUT_W)
    ) left_path (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sample_valid_i(sample_valid_i),
        .sample_i(left_in_i),
        .pcm_mode_i(pcm_mode_i),
        .dither_i(dither_next),
        .anti_clip_i(anti_clip_enable),
        .gain_i(gain_reg),
        .deemphasis_select_i(deemphasis_select),
        .data_o(left_word),
        .zero_det_o(left_zero)
    );

    channel_path #(
        .IN_W(IN_W),
        .OUT_W(OUT_W)
    ) right_path (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .sample_valid_i(sample_valid_i),
        .sample_i(right_in_i),
        .pcm_mode_i(pcm_mode_i),
        .dither_i(dither_next),
        .anti_clip_i(anti_clip_enable),
        .gain_i(gain_reg),
        .deemphasis_select_i(deemphasis_select),
        .data_o(right_word),
        .zero_det_o(right_zero)
    );

    // ----------------------------------------
    // Zero flag selection
    // ----------------------------------------
    always @* begin
        case (zero_flag_source)
            `ZSRC_AND: zero_flag_src = left_zero & right_zero;
            `ZSRC_LEFT: zero_flag_src = left_zero;
            `ZSRC_RIGHT: zero_flag_src = right_zero;
            default: zero_flag_src = 1'b0;
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            zero_flag_out_o <= 1'b0;
            mute_pin_n_o <= 1'b1;
            bitstream_path_gain_select_o <= 1'b0;
        end else begin
            zero_flag_out_o <= zero_flag_force_high | zero_flag_src;
            mute_pin_n_o <= ~(zero_auto_mute_enable & zero_flag_src);
            bitstream_path_gain_select_o <= output_routing_dither_control_reg[`BIT_BITSTREAM_GAIN];
        end
    end

    // ----------------------------------------
    // Output routing and phase
    // ----------------------------------------
    always @* begin
        // Phase inversion applied in stereo and swapped routing only, not in mono
        left_sel = phase_invert ? invert(left_word) : left_word;
        right_sel = phase_invert ? invert(right_word) : right_word;
        case (output_routing_select)
            `ROUTE_SWAPPED: begin
                lp_next = right_sel;
                ln_next = invert(right_sel);
                rp_next = left_sel;
                rn_next = invert(left_sel);
            end
            `ROUTE_MONO_LEFT: begin
                lp_next = left_word;
                ln_next = invert(left_word);
                rp_next = invert(left_word);
                rn_next = left_word;
            end
            `ROUTE_MONO_RIGHT: begin
                lp_next = invert(right_word);
                ln_next = right_word;
                rp_next = right_word;
                rn_next = invert(right_word);
            end
            default: begin
                lp_next = left_sel;
                ln_next = invert(left_sel);
                rp_next = right_sel;
                rn_next = invert(right_sel);
            end
        endcase
    end

    always @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage_valid_reg <= 1'b0;
            out_valid_o <= 1'b0;
            left_out_pos_o <= {OUT_W{1'b0}};
            left_out_neg_o <= {OUT_W{1'b0}};
            right_out_pos_o <= {OUT_W{1'b0}};
            right_out_neg_o <= {OUT_W{1'b0}};
        end else begin
            stage_valid_reg <= sample_valid_i;
            out_valid_o <= stage_valid_reg;
            if (stage_valid_reg) begin
                left_out_pos_o <= lp_next;
                left_out_neg_o <= ln_next;
                right_out_pos_o <= rp_next;
                right_out_neg_o <= rn_next;
            end
        end
    end
endmodule // dac_output_processing

// ==== pcm_source.sv ====
// Far-side sample source feeding PCM pairs into the output block.
// Assumes a free-running clock; calls start just after a rising edge.
`timescale 1ns/100ps
module pcm_source (
    // Clock
    input wire clk_i,
    // Sample stream out
    output logic sample_valid_o,
    output logic [31:0] left_o,
    output logic [31:0] right_o
);
    // Idle stream at time zero
    initial begin
        sample_valid_o = 1'b0;
        left_o = 32'h0;
        right_o = 32'h0;
    end

    // One stereo pair on one strobe, then the words go stale
    task automatic send(input logic [31:0] l, input logic [31:0] r);
        sample_valid_o <= 1'b1;
        left_o <= l;
        right_o <= r;
        @(posedge clk_i);
        sample_valid_o <= 1'b0;
        left_o <= ~l; // Stale words are not held
        right_o <= ~r;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
endmodule // pcm_source

// ==== dac_output_sva.sv ====
// Port checker for the output processing block.
// Assumes a bind to every dac_output_processing instance.
`timescale 1ns/100ps
module dac_output_sva #(
    parameter IN_W = 32,
    parameter OUT_W = 24
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // Register port
    input wire reg_wr_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    // Stream and pins
    input wire sample_valid_i,
    input wire out_valid_o,
    input wire [OUT_W-1:0] left_out_pos_o,
    input wire [OUT_W-1:0] left_out_neg_o,
    input wire [OUT_W-1:0] right_out_pos_o,
    input wire [OUT_W-1:0] right_out_neg_o,
    input wire zero_flag_out_o,
    input wire bitstream_path_gain_select_o,
    input wire soft_mute_done_o
);
    localparam [OUT_W-1:0] MIN_W = {1'b1, {(OUT_W-1){1'b0}}};
    wire mapped_w;

    // Offsets that store data
    assign mapped_w = reg_addr_i inside {8'h04, 8'h05, 8'h06, 8'h08};

    // Negation that clips the most negative word
    function automatic [OUT_W-1:0] neg_sat(input [OUT_W-1:0] w);
        neg_sat = (w == MIN_W) ? ~MIN_W : -w;
    endfunction

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence s_wr(logic [7:0] a);
        reg_wr_i && reg_addr_i == a;
    endsequence
    sequence s_wr_rd;
        reg_wr_i && mapped_w ##1 !reg_wr_i [*3] ##1 reg_rd_i && reg_addr_i == $past(reg_addr_i, 4);
    endsequence

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_READBACK: assert property (s_wr_rd |=> reg_rdata_o == $past(reg_wdata_i, 5))
        else $error("read data differs from last write");
    AST_GAIN_SEL: assert property (s_wr(8'h08) ##0 reg_wdata_i[6] |-> ##[1:2] bitstream_path_gain_select_o)
        else $error("gain select did not follow write");
    AST_FORCE: assert property (s_wr(8'h06) ##0 reg_wdata_i[7] |-> ##[1:2] zero_flag_out_o)
        else $error("zero flag not forced high");
    AST_LATENCY: assert property (sample_valid_i |-> ##2 out_valid_o)
        else $error("output words late");
    AST_PULSE: assert property (out_valid_o |=> !out_valid_o)
        else $error("output strobe longer than one cycle");
    AST_HOLD: assert property (!out_valid_o |-> $stable(left_out_pos_o) && $stable(right_out_pos_o))
        else $error("output words changed between strobes");
    AST_NEG: assert property (out_valid_o |-> left_out_neg_o == neg_sat(left_out_pos_o)
        && right_out_neg_o == neg_sat(right_out_pos_o))
        else $error("negative output not inverse of positive");
    AST_SOFT_ZERO: assert property (soft_mute_done_o && $past(soft_mute_done_o, 3) && out_valid_o
        |-> left_out_pos_o == '0 && right_out_pos_o == '0)
        else $error("output not at midpoint after soft mute");
endmodule // dac_output_sva

bind dac_output_processing dac_output_sva #(.IN_W(IN_W), .OUT_W(OUT_W)) u_sva (.clk_i, .sys_rst_i,
    .reg_wr_i, .reg_addr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .sample_valid_i, .out_valid_o,
    .left_out_pos_o, .left_out_neg_o, .right_out_pos_o, .right_out_neg_o, .zero_flag_out_o,
    .bitstream_path_gain_select_o, .soft_mute_done_o);

// ==== tb_dac_output_processing_controls.sv ====
// Testbench for the output processing block.
// Assumes the design, checker and sample source in the same folder.
`timescale 1ns/100ps
module tb_dac_output_processing_controls;
    logic clk_i, sys_rst_i, reg_wr_i, reg_rd_i, pcm_mode_i, sample_valid_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d;
    logic [31:0] left_in_i, right_in_i;
    logic out_valid_o, zero_flag_out_o, mute_pin_n_o, bitstream_path_gain_select_o, soft_mute_done_o;
    logic [23:0] left_out_pos_o, left_out_neg_o, right_out_pos_o, right_out_neg_o, mag, a, b;
    logic [23:0] ex [4];
    logic [7:0] ofs [5] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h07};
    logic [7:0] rv [5] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
    int errors = 0, num_checks = 0, cnt;

    dac_output_processing dut (.clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
        .reg_rdata_o, .sample_valid_i, .left_in_i, .right_in_i, .pcm_mode_i, .out_valid_o,
        .left_out_pos_o, .left_out_neg_o, .right_out_pos_o, .right_out_neg_o, .zero_flag_out_o,
        .mute_pin_n_o, .bitstream_path_gain_select_o, .soft_mute_done_o);
    pcm_source src (.clk_i, .sample_valid_o(sample_valid_i), .left_o(left_in_i), .right_o(right_in_i));

    // 25 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] v);
        reg_wr_i <= 1'b1;
        reg_addr_i <= ad;
        reg_wdata_i <= v;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        repeat (3) @(posedge clk_i); // Field and flag settle
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] v);
        reg_rd_i <= 1'b1;
        reg_addr_i <= ad;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task automatic cmp4();
        chk("lp", ex[0], left_out_pos_o);
        chk("ln", ex[1], left_out_neg_o);
        chk("rp", ex[2], right_out_pos_o);
        chk("rn", ex[3], right_out_neg_o);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk_i);
        errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        sys_rst_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0; reg_addr_i = 8'h00; reg_wdata_i = 8'h00;
        pcm_mode_i = 1'b1;
        a = 24'h100000;
        b = 24'h200000;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i); #1;
        // Defaults, unmapped read, readback
        foreach (ofs[i]) begin rd(ofs[i], d); chk("rst", 24'(rv[i]), 24'(d)); end
        chk("mute_rst", 24'h1, 24'(mute_pin_n_o));
        wr(8'h07, 8'hFF); rd(8'h07, d); chk("unmapped", 24'h0, 24'(d));
        wr(8'h04, 8'h72); rd(8'h04, d); chk("readback", 24'h72, 24'(d));
        wr(8'h04, 8'h00);
        wr(8'h08, 8'h40); chk("gain_hi", 24'h1, 24'(bitstream_path_gain_select_o));
        wr(8'h08, 8'h00); chk("gain_lo", 24'h0, 24'(bitstream_path_gain_select_o));
        // Routing with phase clear, then phase inversion in stereo
        for (int r = 0; r < 4; r++) begin
            wr(8'h08, 8'(r << 2));
            src.send(32'h10000000, 32'h20000000);
            case (r)
                0: ex = '{a, -a, b, -b};
                1: ex = '{a, -a, -a, a};
                2: ex = '{b, -b, a, -a};
                default: ex = '{-b, b, b, -b};
            endcase
            cmp4();
        end
        wr(8'h08, 8'h00); wr(8'h05, 8'h40);
        src.send(32'h10000000, 32'h20000000);
        ex = '{-a, a, -b, b};
        cmp4();
        wr(8'h05, 8'h00); wr(8'h04, 8'h02);
        src.send(32'h40000000, 32'h40000000);
        ex = '{24'h32D680, -24'h32D680, 24'h32D680, -24'h32D680};
        cmp4();
        wr(8'h04, 8'h00);
        // De-emphasis on alternating half-scale swing
        for (int m = 0; m < 4; m++) begin
            wr(8'h06, 8'(m << 5));
            for (int k = 0; k < 16; k++) src.send(k[0] ? 32'hC0000000 : 32'h40000000, 32'h40000000);
            mag = left_out_pos_o[23] ? -left_out_pos_o : left_out_pos_o;
            chk("deemphasis_select", 24'h1, 24'((m == 0) ? (mag == 24'h400000) : (mag < 24'h300000)));
        end
        wr(8'h06, 8'h00);
        // Dither types
        for (int m = 1; m < 4; m++) begin
            wr(8'h08, 8'(m));
            cnt = 0;
            repeat (8) begin
                src.send(32'h10000000, 32'h10000000);
                mag = left_out_pos_o - a;
                cnt += (mag != 24'h0);
                chk("dith_rng", 24'h1, 24'((mag + 24'h2) <= 24'h4));
            end
            chk("dith_var", 24'h1, 24'(cnt > 0));
        end
        wr(8'h08, 8'h00);
        // Zero runs and flag sources
        repeat (1024) src.send(32'h0, 32'h0);
        chk("zf_1024", 24'h0, 24'(zero_flag_out_o));
        src.send(32'h0, 32'h0);
        chk("zf_1025", 24'h1, 24'(zero_flag_out_o));
        for (int s = 0; s < 4; s++) begin wr(8'(s << 5), 8'h00); end
        for (int s = 0; s < 4; s++) begin wr(8'h04, 8'(s << 5)); chk("zsrc", 24'(s != 3), 24'(zero_flag_out_o)); end
        repeat (1030) src.send(32'h0, 32'h100);
        for (int s = 0; s < 4; s++) begin wr(8'h04, 8'(s << 5)); chk("zsat", 24'(s == 1), 24'(zero_flag_out_o)); end
        wr(8'h04, 8'h30); chk("amute", 24'h0, 24'(mute_pin_n_o));
        wr(8'h04, 8'h50); chk("amute_r", 24'h1, 24'(mute_pin_n_o));
        wr(8'h04, 8'h20); chk("amute_off", 24'h1, 24'(mute_pin_n_o));
        pcm_mode_i <= 1'b0;
        src.send(32'h0, 32'h0); // Zero pair outside PCM mode clears the run
        chk("zf_nopcm", 24'h0, 24'(zero_flag_out_o));
        pcm_mode_i <= 1'b1;
        wr(8'h04, 8'h60); wr(8'h06, 8'h80); chk("force", 24'h1, 24'(zero_flag_out_o));
        wr(8'h06, 8'h00); chk("force_off", 24'h0, 24'(zero_flag_out_o));
        // Soft mute decay and release
        wr(8'h04, 8'h08);
        repeat (2) src.send(32'h40000000, 32'h40000000);
        chk("sm_decay", 24'h1, 24'(left_out_pos_o < 24'h400000 && left_out_pos_o > 24'h0));
        repeat (4087) src.send(32'h40000000, 32'h40000000);
        chk("sm_mid", 24'h0, left_out_pos_o);
        chk("sm_done", 24'h1, 24'(soft_mute_done_o));
        wr(8'h04, 8'h00);
        repeat (2) src.send(32'h40000000, 32'h40000000);
        chk("sm_rel", 24'h400000, right_out_pos_o);
        chk("sm_done0", 24'h0, 24'(soft_mute_done_o));
        end_sim();
    end
endmodule // tb_dac_output_processing_controls
